/* File: dv/sgc_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sgc_card_model (
  // Clock
  input  wire logic       i_clk,
  // Card side lines seen by the controller
  output var  logic [1:0] o_func_irq,
  output var  logic [7:0] o_csc_evt,
  output var  logic       o_cycle_active
);
  // Card lines rest low between requests, as a removed card would leave them
  initial begin
    o_func_irq = 2'h0;
    o_csc_evt = 8'h00;
    o_cycle_active = 1'b0;
  end

  task automatic func_level(input logic [1:0] m, input int n);
    o_func_irq <= m;
    repeat (n) @(posedge i_clk);
    o_func_irq <= 2'h0;
    @(posedge i_clk);
  endtask

  task automatic evt(input logic [7:0] b);
    o_csc_evt <= b;
    @(posedge i_clk);
    o_csc_evt <= 8'h00;
    @(posedge i_clk);
  endtask

  task automatic cycle(input int n);
    o_cycle_active <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_cycle_active <= 1'b0;
    @(posedge i_clk);
  endtask
endmodule // sgc_card_model
`default_nettype wire

/* File: dv/socket_global_ctrl_io_offset_bench.sv */
`include "sgc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module socket_global_ctrl_io_offset_bench;
  import sgc_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        hb_rst = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        reg_sock = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        io_req = 1'b0;
  logic        io_sock = 1'b0;
  logic        io_win = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [15:0] lfsr = 16'h728c;
  wire  [7:0]  rdata;
  wire         rvalid;
  wire  [15:0] card_addr;
  wire         card_valid;
  wire         out_en, irq_a, irq_b, irq_s, cyc;
  wire  [1:0]  func;
  wire  [7:0]  evt;
  sgc_byte_t   rq[$];
  logic [15:0] xq[$];
  int          mismatches = 0;
  int          comparisons = 0;
  int          n_a = 0, n_b = 0, n_s = 0, n_oe = 0;
  int          a0, b0, s0;
  logic [7:0]  lo, hi;

  always #20 i_clk = ~i_clk;

  sgc_card_model card_u (.i_clk(i_clk), .o_func_irq(func), .o_csc_evt(evt), .o_cycle_active(cyc));

  sgc_top dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_host_bus_reset_in(hb_rst),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_sock(reg_sock), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_card_func_irq(func), .i_csc_evt(evt), .i_card_cycle_active(cyc),
    .i_io_req(io_req), .i_io_sock(io_sock), .i_io_win(io_win), .i_io_addr(io_addr),
    .o_card_addr(card_addr), .o_card_addr_valid(card_valid),
    .o_card_out_en(out_en), .o_sock_a_irq(irq_a), .o_sock_b_irq(irq_b), .o_csc_irq(irq_s));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic wr(input logic s, input logic [11:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_sock <= s;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_clk);
    reg_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic s, input logic [11:0] a, input logic [7:0] e);
    rq.push_back(e);
    reg_rd <= 1'b1;
    reg_sock <= s;
    reg_addr <= a;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic io(input logic s, input logic w, input logic [15:0] a, input logic [15:0] e);
    xq.push_back(e);
    io_req <= 1'b1;
    io_sock <= s;
    io_win <= w;
    io_addr <= a;
    @(posedge i_clk);
    io_req <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Results are matched in request order; an answer with no request is itself a fault
  always @(posedge i_clk) begin
    n_a += int'(irq_a === 1'b1);
    n_b += int'(irq_b === 1'b1);
    n_s += int'(irq_s === 1'b1);
    n_oe += int'(out_en === 1'b1);
    if (rvalid === 1'b1) begin
      if (rq.size() == 0) chk("read answer", 16'h0, 16'h1);
      else chk("read data", {8'h00, rq.pop_front()}, {8'h00, rdata});
    end
    if (card_valid === 1'b1) begin
      if (xq.size() == 0) chk("card address answer", 16'h0, 16'h1);
      else chk("card address", xq.pop_front(), card_addr);
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    for (int s = 0; s < 2; s++) begin
      rd(s[0], `SGC_OFS_GCTRL, 8'h00);
      for (int k = 0; k < 4; k++) rd(s[0], `SGC_OFS_IO0_LO + 12'(k), 8'h00);
    end
    rd(1'b0, 12'h800, `SGC_RD_UNMAPPED);
    wr(1'b0, `SGC_OFS_CDGC, 8'h20);
    rd(1'b0, `SGC_OFS_CSC, 8'h00);
    $display("test reset_values done");
    wr(1'b0, `SGC_OFS_GCTRL, 8'hff);
    rd(1'b1, `SGC_OFS_GCTRL, 8'h1f);
    wr(1'b1, `SGC_OFS_GCTRL, 8'h00);
    rd(1'b0, `SGC_OFS_GCTRL, 8'h00);
    $display("test shared_control done");
    for (int i = 0; i < 4; i++) begin
      lo = 8'(rnd());
      hi = 8'(rnd());
      wr(i[1], `SGC_OFS_IO0_LO + 12'(2 * i[0]), lo);
      wr(i[1], `SGC_OFS_IO0_HI + 12'(2 * i[0]), hi);
      rd(i[1], `SGC_OFS_IO0_LO + 12'(2 * i[0]), lo & 8'hfe);
      rd(i[1], `SGC_OFS_IO0_HI + 12'(2 * i[0]), hi);
      a0 = int'(rnd());
      io(i[1], i[0], 16'(a0), 16'(a0) + {hi, lo & 8'hfe});
    end
    $display("test io_offsets done");
    wr(1'b0, `SGC_OFS_GCTRL, 8'h1f);
    wr(1'b0, `SGC_OFS_IO0_HI, 8'h5a);
    card_u.evt(8'h80);
    hb_rst <= 1'b1;
    @(posedge i_clk);
    hb_rst <= 1'b0;
    @(posedge i_clk);
    rd(1'b0, `SGC_OFS_GCTRL, 8'h07);
    rd(1'b0, `SGC_OFS_IO0_HI, 8'h00);
    rd(1'b1, `SGC_OFS_CSC, 8'h08);
    $display("test host_bus_reset done");
    wr(1'b0, `SGC_OFS_GCTRL, 8'h01);
    repeat (2) @(posedge i_clk);
    #1 chk("card output enable", 16'h0, {15'h0, out_en});
    a0 = n_oe;
    @(posedge i_clk);
    card_u.cycle(3);
    repeat (3) @(posedge i_clk);
    chk("driven cycles", 16'd3, 16'(n_oe - a0));
    // Interrupt modes are walked while power-down stays on
    for (int m = 0; m < 4; m++) begin
      wr(1'b0, `SGC_OFS_GCTRL, 8'h01 | 8'(m << 3));
      a0 = n_a;
      b0 = n_b;
      card_u.func_level(2'h3, 8);
      repeat (5) @(posedge i_clk);
      chk("socket a irq cycles", m[0] ? 16'd8 : 16'd1, 16'(n_a - a0));
      chk("socket b irq cycles", m[1] ? 16'd8 : 16'd1, 16'(n_b - b0));
    end
    $display("test power_down_and_irq done");
    wr(1'b0, `SGC_OFS_GCTRL, 8'h00);
    wr(1'b0, `SGC_OFS_CSC_EN, 8'h08);
    s0 = n_s;
    card_u.evt(8'h08);
    repeat (3) @(posedge i_clk);
    chk("status irq pulses", 16'd1, 16'(n_s - s0));
    wr(1'b0, `SGC_OFS_CSC, 8'h08);
    rd(1'b0, `SGC_OFS_CSC, 8'h08);
    rd(1'b0, `SGC_OFS_CSC, 8'h00);
    s0 = n_s;
    card_u.evt(8'h01);
    repeat (3) @(posedge i_clk);
    chk("masked status irq", 16'd0, 16'(n_s - s0));
    rd(1'b0, `SGC_OFS_CSC, 8'h01);
    wr(1'b0, `SGC_OFS_GCTRL, 8'h06);
    card_u.evt(8'h08);
    repeat (2) @(posedge i_clk);
    #1 chk("status irq level", 16'h1, {15'h0, irq_s});
    @(posedge i_clk);
    rd(1'b0, `SGC_OFS_CSC, 8'h08);
    rd(1'b0, `SGC_OFS_CSC, 8'h08);
    wr(1'b0, `SGC_OFS_CSC, 8'h08);
    repeat (2) @(posedge i_clk);
    #1 chk("status irq released", 16'h0, {15'h0, irq_s});
    @(posedge i_clk);
    wr(1'b0, `SGC_OFS_CDGC, 8'h20);
    repeat (2) @(posedge i_clk);
    rd(1'b0, `SGC_OFS_CSC, 8'h08);
    wr(1'b0, `SGC_OFS_CSC, 8'h08);
    repeat (3) @(posedge i_clk);
    rd(1'b0, `SGC_OFS_CSC, 8'h00);
    $display("test status_change done");
    repeat (4) @(posedge i_clk);
    chk("pending answers", 16'h0, 16'(rq.size() + xq.size()));
    tally_and_finish();
  end
endmodule // socket_global_ctrl_io_offset_bench
`default_nettype wire

/* File: hdl/sgc_cfg.svh */
`ifndef SGC_CFG_SVH
`define SGC_CFG_SVH

// Register offsets from the socket base address
`define SGC_OFS_CSC       12'h804
`define SGC_OFS_CSC_EN    12'h805
`define SGC_OFS_CDGC      12'h816
`define SGC_OFS_GCTRL     12'h81e
`define SGC_OFS_IO0_LO    12'h836
`define SGC_OFS_IO0_HI    12'h837
`define SGC_OFS_IO1_LO    12'h838
`define SGC_OFS_IO1_HI    12'h839

// Shared global control field positions and reset value
`define SGC_GC_SOCKB_LVL  4
`define SGC_GC_SOCKA_LVL  3
`define SGC_GC_CLR_BY_WR  2
`define SGC_GC_CSC_LVL    1
`define SGC_GC_PWR_DOWN   0
`define SGC_GC_RESET      5'h00

// Status-change flag and soft card-detect positions
`define SGC_CSC_CD_BIT    3
`define SGC_SOFT_CD_BIT   5

// Read data for offsets that hold nothing
`define SGC_RD_UNMAPPED   8'h00
// Card outputs are driven after reset since power-down starts off
`define SGC_CARD_OE_RESET 1'b1

`endif

/* File: hdl/sgc_io_xlate.sv */
`timescale 1ns/1ps
`default_nettype none
module sgc_io_xlate
  import sgc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Host side
  input  wire logic              i_req,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [ADDR_W-1:0] i_offset,
  // Card side
  output logic      [ADDR_W-1:0] o_addr,
  output logic                   o_valid
);

  sgc_xlate_s xl_reg;
  sgc_xlate_s xl_next;

  always_comb begin
    xl_next       = xl_reg;
    xl_next.valid = i_req;
    // Offset wraps modulo 64K, as the card address space does
    if (i_req) begin
      xl_next.addr = i_addr + i_offset;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      xl_reg <= '0;
    end else begin
      xl_reg <= xl_next;
    end
  end

  assign o_addr  = xl_reg.addr;
  assign o_valid = xl_reg.valid;

endmodule // sgc_io_xlate
`default_nettype wire

/* File: hdl/sgc_irq_signal.sv */
`timescale 1ns/1ps
`default_nettype none
module sgc_irq_signal
  import sgc_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Condition and mode
  input  wire logic i_pending,
  input  wire logic i_level_mode,
  // Host request
  output logic      o_irq
);

  sgc_irq_s irq_reg;
  sgc_irq_s irq_next;

  always_comb begin
    irq_next        = irq_reg;
    irq_next.pend_d = i_pending;
    // Edge mode pulses once per new condition, level mode follows it
    if (i_level_mode) begin
      irq_next.irq = i_pending;
    end else begin
      irq_next.irq = i_pending & ~irq_reg.pend_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_reg <= '0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign o_irq = irq_reg.irq;

endmodule // sgc_irq_signal
`default_nettype wire

/* File: hdl/sgc_pkg.sv */
package sgc_pkg;

  typedef logic [7:0] sgc_byte_t;

  typedef struct packed {
    logic [4:0]            gctrl;
    logic [1:0][1:0][7:1]  io_lo;
    logic [1:0][1:0][7:0]  io_hi;
    logic [1:0][3:0]       status_change_flags;
    logic [1:0][3:0]       csc_en;
    logic [1:0]            soft_cd;
    logic [1:0]            func_s1;
    logic [1:0]            func_s2;
    sgc_byte_t             rdata;
    logic                  rvalid;
    logic                  card_oe;
  } sgc_top_s;

  typedef struct packed {
    logic pend_d;
    logic irq;
  } sgc_irq_s;

  typedef struct packed {
    logic [15:0] addr;
    logic        valid;
  } sgc_xlate_s;

endpackage

/* File: hdl/sgc_top.sv */
// Contract
// - Global control bits 7 to 5 always read zero and ignore writes.
// - One global control register serves both sockets, whichever socket addresses it.
// - Global control bit 4 picks edge (0, reset) or level (1) host signalling for socket B card interrupts.
// - Global control bit 3 picks edge (0, reset) or level (1) host signalling for socket A card interrupts.
// - Bit 2 low makes a read of the status-change register clear its flags; high makes only a written 1 clear a flag.
// - Global control bit 1 picks edge (0, reset) or level (1) signalling for the status-change host interrupt.
// - With bit 0 set, card outputs float except while a card cycle is active.
// - In power-down, card and status-change interrupts still come through; only a card access wakes the interface.
// - Bits 2, 1 and 0 are cleared by the global reset only, never by the host bus reset.
// - Each socket has I/O windows 0 and 1 with a 16-bit offset in separate low and high bytes, reset to zero.
// - The low offset byte stores bits 7 to 1 and reads bit 0 as zero.
// - The high offset byte stores all eight bits.
// - Clearing the card-detect change flag by a written 1 also clears the pending soft card-detect event.
`include "sgc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sgc_top
  import sgc_pkg::*;
(
  // Clock and resets (i_rst is the global reset)
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_host_bus_reset_in,
  // Register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic        i_reg_sock,
  input  wire logic [11:0] i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rvalid,
  // Card events
  input  wire logic [1:0]  i_card_func_irq,
  input  wire logic [7:0]  i_csc_evt,
  input  wire logic        i_card_cycle_active,
  // I/O window translation
  input  wire logic        i_io_req,
  input  wire logic        i_io_sock,
  input  wire logic        i_io_win,
  input  wire logic [15:0] i_io_addr,
  output logic      [15:0] o_card_addr,
  output logic             o_card_addr_valid,
  // Card output enable and host interrupts
  output logic             o_card_out_en,
  output logic             o_sock_a_irq,
  output logic             o_sock_b_irq,
  output logic             o_csc_irq
);

  sgc_top_s    r;
  sgc_top_s    n;
  logic [15:0] io_offset;
  logic        csc_pend;

  function automatic logic [15:0] win_offset(input logic [7:1] lo, input logic [7:0] hi);
    win_offset = {hi, lo, 1'b0};
  endfunction

  always_comb begin
    sgc_byte_t       rd;
    logic [1:0][3:0] clr;
    logic [1:0]      soft_set;
    logic [3:0]      set;
    rd       = `SGC_RD_UNMAPPED;
    clr      = '0;
    soft_set = '0;
    set      = '0;
    n        = r;
    n.rvalid = 1'b0;
    n.func_s1 = i_card_func_irq;
    n.func_s2 = r.func_s1;
    // Power-down floats outputs unless a card cycle runs
    n.card_oe = ~r.gctrl[`SGC_GC_PWR_DOWN] | i_card_cycle_active;

    if (i_reg_wr) begin
      if (i_reg_addr == `SGC_OFS_GCTRL) begin
        n.gctrl = i_reg_wdata[4:0];
      end else if (i_reg_addr == `SGC_OFS_IO0_LO) begin
        n.io_lo[i_reg_sock][0] = i_reg_wdata[7:1];
      end else if (i_reg_addr == `SGC_OFS_IO0_HI) begin
        n.io_hi[i_reg_sock][0] = i_reg_wdata;
      end else if (i_reg_addr == `SGC_OFS_IO1_LO) begin
        n.io_lo[i_reg_sock][1] = i_reg_wdata[7:1];
      end else if (i_reg_addr == `SGC_OFS_IO1_HI) begin
        n.io_hi[i_reg_sock][1] = i_reg_wdata;
      end else if (i_reg_addr == `SGC_OFS_CSC_EN) begin
        n.csc_en[i_reg_sock] = i_reg_wdata[3:0];
      end else if (i_reg_addr == `SGC_OFS_CDGC) begin
        soft_set[i_reg_sock] = i_reg_wdata[`SGC_SOFT_CD_BIT] & r.csc_en[i_reg_sock][`SGC_CSC_CD_BIT];
      end else if (i_reg_addr == `SGC_OFS_CSC) begin
        if (r.gctrl[`SGC_GC_CLR_BY_WR]) begin
          clr[i_reg_sock] = i_reg_wdata[3:0];
        end
      end
    end

    if (i_reg_rd) begin
      n.rvalid = 1'b1;
      if (i_reg_addr == `SGC_OFS_GCTRL) begin
        rd = {3'h0, r.gctrl};
      end else if (i_reg_addr == `SGC_OFS_IO0_LO) begin
        rd = {r.io_lo[i_reg_sock][0], 1'b0};
      end else if (i_reg_addr == `SGC_OFS_IO0_HI) begin
        rd = r.io_hi[i_reg_sock][0];
      end else if (i_reg_addr == `SGC_OFS_IO1_LO) begin
        rd = {r.io_lo[i_reg_sock][1], 1'b0};
      end else if (i_reg_addr == `SGC_OFS_IO1_HI) begin
        rd = r.io_hi[i_reg_sock][1];
      end else if (i_reg_addr == `SGC_OFS_CSC_EN) begin
        rd = {4'h0, r.csc_en[i_reg_sock]};
      end else if (i_reg_addr == `SGC_OFS_CSC) begin
        rd = {4'h0, r.status_change_flags[i_reg_sock]};
        if (!r.gctrl[`SGC_GC_CLR_BY_WR]) begin
          clr[i_reg_sock] = 4'hf;
        end
      end
      n.rdata = rd;
    end

    // Flags keep taking events in power-down; a set in the clearing cycle wins
    for (int s = 0; s < 2; s++) begin
      set = i_csc_evt[s*4 +: 4];
      set[`SGC_CSC_CD_BIT] = set[`SGC_CSC_CD_BIT] | soft_set[s]
                             | (r.soft_cd[s] & ~clr[s][`SGC_CSC_CD_BIT]);
      n.status_change_flags[s] = (r.status_change_flags[s] & ~clr[s]) | set;
      n.soft_cd[s] = (r.soft_cd[s] & ~clr[s][`SGC_CSC_CD_BIT]) | soft_set[s];
    end

    // Host bus reset leaves the global-reset-only bits alone
    if (i_host_bus_reset_in) begin
      n.gctrl[`SGC_GC_SOCKB_LVL] = 1'b0;
      n.gctrl[`SGC_GC_SOCKA_LVL] = 1'b0;
      n.io_lo  = '0;
      n.io_hi  = '0;
      n.csc_en = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r         <= '0;
      r.gctrl   <= `SGC_GC_RESET;
      r.card_oe <= `SGC_CARD_OE_RESET;
    end else begin
      r <= n;
    end
  end

  assign io_offset = win_offset(r.io_lo[i_io_sock][i_io_win], r.io_hi[i_io_sock][i_io_win]);
  assign csc_pend  = |(r.status_change_flags[0] & r.csc_en[0]) | |(r.status_change_flags[1] & r.csc_en[1]);

  sgc_io_xlate #(
    .ADDR_W (16)
  ) u_xlate (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_req    (i_io_req),
    .i_addr   (i_io_addr),
    .i_offset (io_offset),
    .o_addr   (o_card_addr),
    .o_valid  (o_card_addr_valid)
  );

  sgc_irq_signal u_irq_a (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_pending    (r.func_s2[0]),
    .i_level_mode (r.gctrl[`SGC_GC_SOCKA_LVL]),
    .o_irq        (o_sock_a_irq)
  );

  sgc_irq_signal u_irq_b (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_pending    (r.func_s2[1]),
    .i_level_mode (r.gctrl[`SGC_GC_SOCKB_LVL]),
    .o_irq        (o_sock_b_irq)
  );

  sgc_irq_signal u_irq_csc (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_pending    (csc_pend),
    .i_level_mode (r.gctrl[`SGC_GC_CSC_LVL]),
    .o_irq        (o_csc_irq)
  );

  assign o_reg_rdata   = r.rdata;
  assign o_reg_rvalid  = r.rvalid;
  assign o_card_out_en = r.card_oe;

  // Checks read the registered state; host bus reset is kept out wherever it would override a write
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_gc_upper_zero: assert property (
    i_reg_rd && i_reg_addr == `SGC_OFS_GCTRL |=> o_reg_rvalid && o_reg_rdata[7:5] == 3'h0)
    else $error("global control upper bits read nonzero");

  chk_gc_shared_copy: assert property (
    (i_reg_wr && !i_reg_rd && i_reg_addr == `SGC_OFS_GCTRL && !i_host_bus_reset_in)
    ##1 (!i_reg_wr && !i_host_bus_reset_in)
    ##1 (i_reg_rd && !i_reg_wr && i_reg_addr == `SGC_OFS_GCTRL && !i_host_bus_reset_in
         && i_reg_sock != $past(i_reg_sock, 2))
    |=> o_reg_rdata[4:0] == $past(i_reg_wdata[4:0], 3))
    else $error("global control differs between sockets");

  chk_sockb_level_hold: assert property (
    r.gctrl[`SGC_GC_SOCKB_LVL] && r.func_s2[1] |=> o_sock_b_irq)
    else $error("socket B level request missing");

  chk_socka_edge_pulse: assert property (
    o_sock_a_irq && !r.gctrl[`SGC_GC_SOCKA_LVL] |=> !o_sock_a_irq)
    else $error("socket A edge request longer than one cycle");

  chk_csc_read_clear: assert property (
    i_reg_rd && !i_reg_wr && !i_reg_sock && i_reg_addr == `SGC_OFS_CSC
    && !r.gctrl[`SGC_GC_CLR_BY_WR] && i_csc_evt[3:0] == 4'h0 |=> r.status_change_flags[0] == 4'h0)
    else $error("read did not clear status-change flags");

  chk_csc_write_ignored: assert property (
    i_reg_wr && !i_reg_rd && i_reg_addr == `SGC_OFS_CSC && !r.gctrl[`SGC_GC_CLR_BY_WR]
    && r.status_change_flags[0][`SGC_CSC_CD_BIT] |=> r.status_change_flags[0][`SGC_CSC_CD_BIT])
    else $error("write cleared a flag in read-clear mode");

  chk_csc_level_hold: assert property (
    r.gctrl[`SGC_GC_CSC_LVL] && |(r.status_change_flags[0] & r.csc_en[0]) |=> o_csc_irq)
    else $error("status-change level request missing");

  chk_pd_outputs_float: assert property (
    r.gctrl[`SGC_GC_PWR_DOWN] && !i_card_cycle_active |=> !o_card_out_en)
    else $error("card outputs driven in power-down idle");

  chk_pd_irq_alive: assert property (
    r.gctrl[`SGC_GC_PWR_DOWN] && r.gctrl[`SGC_GC_SOCKA_LVL] && r.func_s2[0] |=> o_sock_a_irq)
    else $error("card interrupt lost in power-down");

  chk_hostrst_keeps_bits: assert property (
    i_host_bus_reset_in && !i_reg_wr |=> r.gctrl[2:0] == $past(r.gctrl[2:0]) && r.gctrl[4:3] == 2'h0)
    else $error("host bus reset disturbed global-reset-only bits");

  chk_io_zero_on_reset: assert property (
    i_host_bus_reset_in |=> r.io_lo == '0 && r.io_hi == '0)
    else $error("window offsets not cleared by reset");

  chk_iolo_bit0_zero: assert property (
    i_reg_rd && (i_reg_addr == `SGC_OFS_IO0_LO || i_reg_addr == `SGC_OFS_IO1_LO) |=> o_reg_rdata[0] == 1'b0)
    else $error("low offset bit 0 read as one");

  chk_iohi_readback: assert property (
    (i_reg_wr && !i_reg_rd && i_reg_addr == `SGC_OFS_IO1_HI && !i_host_bus_reset_in)
    ##1 (!i_reg_wr && !i_host_bus_reset_in) [*3]
    ##1 (i_reg_rd && !i_reg_wr && i_reg_addr == `SGC_OFS_IO1_HI && !i_host_bus_reset_in
         && i_reg_sock == $past(i_reg_sock, 4))
    |=> o_reg_rdata == $past(i_reg_wdata, 5))
    else $error("high offset byte did not read back");

  chk_soft_cd_cleared: assert property (
    i_reg_wr && !i_reg_rd && !i_reg_sock && i_reg_addr == `SGC_OFS_CSC && r.gctrl[`SGC_GC_CLR_BY_WR]
    && i_reg_wdata[`SGC_CSC_CD_BIT] && !i_csc_evt[`SGC_CSC_CD_BIT] |=> !r.soft_cd[0] && !r.status_change_flags[0][3])
    else $error("soft card-detect event survived its clear");

  chk_io_xlate_sum: assert property (
    i_io_req |=> o_card_addr_valid && o_card_addr == $past(i_io_addr) + $past(io_offset))
    else $error("card address is not host address plus offset");

  chk_csc_edge_once: assert property (
    !r.gctrl[`SGC_GC_CSC_LVL] && csc_pend && $past(csc_pend) |=> !o_csc_irq)
    else $error("edge request repeated for the same condition");

  chk_cycle_drives_out: assert property (
    i_card_cycle_active |=> o_card_out_en)
    else $error("card outputs not driven during a card cycle");

  chk_sockb_edge_pulse: assert property (
    o_sock_b_irq && !r.gctrl[`SGC_GC_SOCKB_LVL] |=> !o_sock_b_irq)
    else $error("socket B edge request longer than one cycle");

  chk_hostrst_keeps_flags: assert property (
    i_host_bus_reset_in && !i_reg_wr && !i_reg_rd && i_csc_evt == 8'h00 |=> r.status_change_flags == $past(r.status_change_flags))
    else $error("host bus reset disturbed status-change flags");

  chk_soft_cd_needs_en: assert property (
    i_reg_wr && !i_reg_sock && i_reg_addr == `SGC_OFS_CDGC && !r.csc_en[0][`SGC_CSC_CD_BIT] && !r.soft_cd[0]
    |=> !r.soft_cd[0])
    else $error("soft card-detect event set while its enable is off");

  chk_xlate_valid_pulse: assert property (
    !i_io_req |=> !o_card_addr_valid)
    else $error("card address valid without a request");

  cov_pd_card_cycle: cover property (r.gctrl[`SGC_GC_PWR_DOWN] && i_card_cycle_active ##1 o_card_out_en);
  cov_hostrst_in_pd: cover property (i_host_bus_reset_in && r.gctrl[`SGC_GC_PWR_DOWN]);
  cov_csc_write_clear: cover property (i_reg_wr && i_reg_addr == `SGC_OFS_CSC && r.gctrl[`SGC_GC_CLR_BY_WR]);
  cov_soft_cd_event: cover property (i_reg_wr && i_reg_addr == `SGC_OFS_CDGC ##1 r.soft_cd != 2'h0);
  cov_io_xlate_win1: cover property (i_io_req && i_io_win && io_offset != 16'h0000);

endmodule // sgc_top
`default_nettype wire
